// ---- shared/status_pkg.sv ----
// Package with set indices, bit positions, access codes and preset values
package status_pkg;
    localparam int REG_W    = 16;
    localparam int NUM_SETS = 8;
    localparam int SET_W    = 3;

    // Register set indices
    localparam logic [2:0] SET_OPERATION   = 3'h0;
    localparam logic [2:0] SET_CALIBRATING = 3'h1;
    localparam logic [2:0] SET_LOWER_FAIL  = 3'h2;
    localparam logic [2:0] SET_MEASURING   = 3'h3;
    localparam logic [2:0] SET_SENSOR_MEM  = 3'h4;
    localparam logic [2:0] SET_TRIG_WAIT   = 3'h5;
    localparam logic [2:0] SET_UPPER_FAIL  = 3'h6;
    localparam logic [2:0] SET_QUESTIONABLE = 3'h7;

    // Register selector inside a set
    typedef enum logic [2:0] {
        SEL_CONDITION  = 3'h0,
        SEL_EVENT      = 3'h1,
        SEL_ENABLE     = 3'h2,
        SEL_POS_FILTER = 3'h3,
        SEL_NEG_FILTER = 3'h4
    } reg_sel_t;

    // Top operation set bit positions
    localparam int OP_CAL_BIT   = 0;
    localparam int OP_MEAS_BIT  = 4;
    localparam int OP_TRIG_BIT  = 5;
    localparam int OP_SENSE_BIT = 10;
    localparam int OP_LLF_BIT   = 11;
    localparam int OP_ULF_BIT   = 12;
    // Top questionable set bit positions
    localparam int QU_POWER_BIT = 3;
    localparam int QU_CAL_BIT   = 8;
    localparam int QU_POST_BIT  = 9;
    // Child set bit positions
    localparam int CH_A_BIT     = 1;
    localparam int CH_B_BIT     = 2;
    localparam int WIN_UP_BIT   = 3;
    localparam int WIN_LO_BIT   = 4;
    localparam int ZERO_BIT     = 15;

    localparam logic [15:0] ALL_ZEROS = 16'h0000;
    localparam logic [15:0] ALL_ONES  = 16'h7FFF;
    localparam logic [15:0] WR_MASK   = 16'h7FFF;

    // Host access request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [2:0]  set_idx;
        reg_sel_t    sel;
        logic [15:0] wdata;
    } host_req_t;

    // Per-channel activity from measurement, calibration and trigger logic
    typedef struct packed {
        logic cal_start;
        logic cal_done;
        logic measuring;
        logic sensor_mem_read;
        logic trig_enter_wait;
        logic trig_enter_idle;
    } chan_status_t;

    // Limit test results for all four targets (ch A, ch B, up win, lo win)
    typedef struct packed {
        logic [3:0] measured;
        logic [3:0] lower_en;
        logic [3:0] lower_fail;
        logic [3:0] upper_en;
        logic [3:0] upper_fail;
    } limit_result_t;
endpackage

// ---- verilog/status_set.sv ----
// One status register set: condition, event, enable and transition filters
`timescale 1ns/100ps
module status_set #(
    parameter int          W         = 16,
    parameter logic [15:0] EN_PRESET = 16'h7FFF
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] cond_i,
    input  wire logic         preset_i,
    input  wire logic         wr_en_i,
    input  wire logic         wr_pos_i,
    input  wire logic         wr_neg_i,
    input  wire logic         rd_event_i,
    input  wire logic [W-1:0] wdata_i,
    output logic      [W-1:0] cond_o,
    output logic      [W-1:0] event_o,
    output logic      [W-1:0] enable_o,
    output logic      [W-1:0] pos_o,
    output logic      [W-1:0] neg_o,
    output logic              summary_o
);
    import status_pkg::*;

    logic [W-1:0] cond_r;
    logic [W-1:0] event_r;
    logic [W-1:0] enable_r;
    logic [W-1:0] pos_r;
    logic [W-1:0] neg_r;
    logic [W-1:0] hits;
    logic         summary_r;

    // Edge detect against the previous sample of the condition
    always_comb begin
        hits = (cond_i & ~cond_r & pos_r) | (~cond_i & cond_r & neg_r);
        hits[ZERO_BIT] = 1'b0;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cond_r <= '0;
        end else begin
            cond_r <= cond_i;
        end
    end

    // A new event in the read cycle survives the read clear
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            event_r <= '0;
        end else if (rd_event_i) begin
            event_r <= hits;
        end else begin
            event_r <= event_r | hits;
        end
    end

    // Preset beats a same-cycle write; condition and event stay untouched
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || preset_i) begin
            enable_r <= EN_PRESET[W-1:0];
            pos_r    <= ALL_ONES[W-1:0];
            neg_r    <= ALL_ZEROS[W-1:0];
        end else begin
            if (wr_en_i) enable_r <= wdata_i & WR_MASK[W-1:0];
            if (wr_pos_i) pos_r   <= wdata_i & WR_MASK[W-1:0];
            if (wr_neg_i) neg_r   <= wdata_i & WR_MASK[W-1:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            summary_r <= 1'b0;
        end else begin
            summary_r <= |(event_r & enable_r);
        end
    end

    assign cond_o    = cond_i & WR_MASK[W-1:0];
    assign event_o   = event_r;
    assign enable_o  = enable_r;
    assign pos_o     = pos_r;
    assign neg_o     = neg_r;
    assign summary_o = summary_r;
endmodule // status_set

// ---- verilog/operation_questionable_status_regs.sv ----
// Operation and questionable status register sets with preset and read-back
//
// Overview of operation
// - Top operation bits 0,4,5,10,11,12 summarise calibrating..upper fail sets.
// - Bit 15 reads zero in every register whatever is written.
// - Calibrating bit for channel A/B sets when zeroing or calibration begins.
// - Combined calibrate-and-report query also sets the calibrating bit at start.
// - Calibrating bit clears when that zeroing or calibration completes.
// - Lower-limit-fail set: bit1 A, bit2 B, bit3 upper window, bit4 lower window.
// - Lower-limit-fail bit sets when the matching lower limit test fails.
// - Limit fail bits clear only on an enabled, passing measurement.
// - Upper-limit-fail set uses same layout; bit sets when upper test fails.
// - Measuring bit per channel is high while that channel measures.
// - Sensor-memory bit per channel is high only while reading its memory.
// - Trigger bit sets on entering wait-for-trigger, clears on idle.
// - Preset: top sets enable zeros, others ones; positive ones, negative zeros.
// - Preset leaves condition and event registers unchanged.
// - Top questionable: bit3 power, bit8 calibration, bit9 self-test result.
// - Each parent summary bit is OR of enabled child event bits.
// - Reading an event register returns it then clears it.
// - Reading a condition register returns live bits, unchanged.
`timescale 1ns/100ps
module operation_questionable_status_regs #(
    parameter int W = 16
) (
    input  wire logic                     sys_clk_i,
    input  wire logic                     rst_n_i,
    input  wire status_pkg::host_req_t    req_i,
    input  wire logic                     preset_i,
    input  wire status_pkg::chan_status_t chan_a_i,
    input  wire status_pkg::chan_status_t chan_b_i,
    input  wire status_pkg::limit_result_t limit_i,
    input  wire logic                     power_summary_i,
    input  wire logic                     cal_quality_summary_i,
    input  wire logic                     self_test_fail_i,
    output logic [W-1:0]                  rdata_o,
    output logic                          rvalid_o,
    output logic                          op_summary_o,
    output logic                          ques_summary_o
);
    import status_pkg::*;

    // Two measurement channels and four limit targets per limit set
    localparam int NUM_CHAN = 2;
    localparam int NUM_TGT  = 4;

    // Conditions of every set, index = set number
    logic [W-1:0] cond      [NUM_SETS];
    logic [W-1:0] cond_rd   [NUM_SETS];
    logic [W-1:0] event_rd  [NUM_SETS];
    logic [W-1:0] enable_rd [NUM_SETS];
    logic [W-1:0] pos_rd    [NUM_SETS];
    logic [W-1:0] neg_rd    [NUM_SETS];
    logic         summary   [NUM_SETS];

    logic [1:0]   cal_r;
    logic [1:0]   trig_r;
    logic [3:0]   lower_r;
    logic [3:0]   upper_r;
    logic [W-1:0] rdata_r;
    logic         rvalid_r;
    logic [W-1:0] rd_mux;

    // Per-set access strobes, bit index = set number
    logic [NUM_SETS-1:0] wr_en_stb;
    logic [NUM_SETS-1:0] wr_pos_stb;
    logic [NUM_SETS-1:0] wr_neg_stb;
    logic [NUM_SETS-1:0] rd_event_stb;
    chan_status_t        chan [NUM_CHAN];

    // Set select decode, used for writes and event-read clear
    function automatic logic hit(input host_req_t r, input int s,
                                 input reg_sel_t k);
        hit = (r.set_idx == s[2:0]) && (r.sel == k);
    endfunction

    // One decode per register kind, so each set sees a single-cycle pulse
    always_comb begin
        for (int i = 0; i < NUM_SETS; i++) begin
            wr_en_stb[i]    = req_i.wr && hit(req_i, i, SEL_ENABLE);
            wr_pos_stb[i]   = req_i.wr && hit(req_i, i, SEL_POS_FILTER);
            wr_neg_stb[i]   = req_i.wr && hit(req_i, i, SEL_NEG_FILTER);
            rd_event_stb[i] = req_i.rd && hit(req_i, i, SEL_EVENT);
        end
    end

    assign chan[0] = chan_a_i;
    assign chan[1] = chan_b_i;

    // Per channel: a start beats a same-cycle done, a wait beats an idle
    genvar c;
    generate
        for (c = 0; c < NUM_CHAN; c++) begin : g_chan
            always_ff @(posedge sys_clk_i) begin
                if (!rst_n_i) begin
                    cal_r[c] <= 1'b0;
                end else if (chan[c].cal_start) begin
                    cal_r[c] <= 1'b1;
                end else if (chan[c].cal_done) begin
                    cal_r[c] <= 1'b0;
                end
            end

            always_ff @(posedge sys_clk_i) begin
                if (!rst_n_i) begin
                    trig_r[c] <= 1'b0;
                end else if (chan[c].trig_enter_wait) begin
                    trig_r[c] <= 1'b1;
                end else if (chan[c].trig_enter_idle) begin
                    trig_r[c] <= 1'b0;
                end
            end
        end
    endgenerate

    // Limit fail bits: a failure sets, only an enabled pass clears
    genvar t;
    generate
        for (t = 0; t < NUM_TGT; t++) begin : g_limit
            always_ff @(posedge sys_clk_i) begin
                if (!rst_n_i) begin
                    lower_r[t] <= 1'b0;
                end else if (limit_i.lower_fail[t]) begin
                    lower_r[t] <= 1'b1;
                end else if (limit_i.measured[t] &&
                             limit_i.lower_en[t]) begin
                    lower_r[t] <= 1'b0;
                end
            end

            always_ff @(posedge sys_clk_i) begin
                if (!rst_n_i) begin
                    upper_r[t] <= 1'b0;
                end else if (limit_i.upper_fail[t]) begin
                    upper_r[t] <= 1'b1;
                end else if (limit_i.measured[t] &&
                             limit_i.upper_en[t]) begin
                    upper_r[t] <= 1'b0;
                end
            end
        end
    endgenerate

    // Condition vectors; unused bits tie low
    always_comb begin
        for (int s = 0; s < NUM_SETS; s++) begin
            cond[s] = '0;
        end
        cond[SET_CALIBRATING][CH_A_BIT] = cal_r[0];
        cond[SET_CALIBRATING][CH_B_BIT] = cal_r[1];
        cond[SET_LOWER_FAIL][CH_A_BIT]   = lower_r[0];
        cond[SET_LOWER_FAIL][CH_B_BIT]   = lower_r[1];
        cond[SET_LOWER_FAIL][WIN_UP_BIT] = lower_r[2];
        cond[SET_LOWER_FAIL][WIN_LO_BIT] = lower_r[3];
        cond[SET_MEASURING][CH_A_BIT] = chan_a_i.measuring;
        cond[SET_MEASURING][CH_B_BIT] = chan_b_i.measuring;
        cond[SET_SENSOR_MEM][CH_A_BIT] = chan_a_i.sensor_mem_read;
        cond[SET_SENSOR_MEM][CH_B_BIT] = chan_b_i.sensor_mem_read;
        cond[SET_TRIG_WAIT][CH_A_BIT] = trig_r[0];
        cond[SET_TRIG_WAIT][CH_B_BIT] = trig_r[1];
        cond[SET_UPPER_FAIL][CH_A_BIT]   = upper_r[0];
        cond[SET_UPPER_FAIL][CH_B_BIT]   = upper_r[1];
        cond[SET_UPPER_FAIL][WIN_UP_BIT] = upper_r[2];
        cond[SET_UPPER_FAIL][WIN_LO_BIT] = upper_r[3];
        // Parent bits are the child summaries directly, one clock behind child events
        cond[SET_OPERATION][OP_CAL_BIT]   = summary[SET_CALIBRATING];
        cond[SET_OPERATION][OP_MEAS_BIT]  = summary[SET_MEASURING];
        cond[SET_OPERATION][OP_TRIG_BIT]  = summary[SET_TRIG_WAIT];
        cond[SET_OPERATION][OP_SENSE_BIT] = summary[SET_SENSOR_MEM];
        cond[SET_OPERATION][OP_LLF_BIT]   = summary[SET_LOWER_FAIL];
        cond[SET_OPERATION][OP_ULF_BIT]   = summary[SET_UPPER_FAIL];
        cond[SET_QUESTIONABLE][QU_POWER_BIT] = power_summary_i;
        cond[SET_QUESTIONABLE][QU_CAL_BIT]   = cal_quality_summary_i;
        cond[SET_QUESTIONABLE][QU_POST_BIT]  = self_test_fail_i;
    end

    // Eight identical sets; only the two top sets preset enable to zeros
    genvar s;
    generate
        for (s = 0; s < NUM_SETS; s++) begin : g_set
            localparam logic [15:0] EN_P =
                (s == SET_OPERATION || s == SET_QUESTIONABLE) ?
                ALL_ZEROS : ALL_ONES;
            status_set #(
                .W         (W),
                .EN_PRESET (EN_P)
            ) u_set (
                .sys_clk_i  (sys_clk_i),
                .rst_n_i    (rst_n_i),
                .cond_i     (cond[s]),
                .preset_i   (preset_i),
                .wr_en_i    (wr_en_stb[s]),
                .wr_pos_i   (wr_pos_stb[s]),
                .wr_neg_i   (wr_neg_stb[s]),
                .rd_event_i (rd_event_stb[s]),
                .wdata_i    (req_i.wdata),
                .cond_o     (cond_rd[s]),
                .event_o    (event_rd[s]),
                .enable_o   (enable_rd[s]),
                .pos_o      (pos_rd[s]),
                .neg_o      (neg_rd[s]),
                .summary_o  (summary[s])
            );
        end
    endgenerate

    // Selector picks one register of the addressed set
    always_comb begin
        rd_mux = '0;
        unique case (req_i.sel)
            SEL_CONDITION:  rd_mux = cond_rd[req_i.set_idx];
            SEL_EVENT:      rd_mux = event_rd[req_i.set_idx];
            SEL_ENABLE:     rd_mux = enable_rd[req_i.set_idx];
            SEL_POS_FILTER: rd_mux = pos_rd[req_i.set_idx];
            SEL_NEG_FILTER: rd_mux = neg_rd[req_i.set_idx];
            default:        rd_mux = '0;
        endcase
    end

    // Read data held until the next read, so a slow controller still sees it
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rdata_r <= '0;
        end else if (req_i.rd) begin
            rdata_r <= rd_mux;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= req_i.rd;
        end
    end

    assign rdata_o        = rdata_r & WR_MASK[W-1:0];
    assign rvalid_o       = rvalid_r;
    assign op_summary_o   = summary[SET_OPERATION];
    assign ques_summary_o = summary[SET_QUESTIONABLE];
endmodule // operation_questionable_status_regs

// ---- dv/status_regs_chk.sv ----
// Port checker for the status register bank
`timescale 1ns/100ps
module status_regs_chk #(
    parameter int W = 16
) (
    input wire logic                      sys_clk_i,
    input wire logic                      rst_n_i,
    input wire status_pkg::host_req_t     req_i,
    input wire logic                      preset_i,
    input wire status_pkg::chan_status_t  chan_a_i,
    input wire status_pkg::chan_status_t  chan_b_i,
    input wire status_pkg::limit_result_t limit_i,
    input wire logic                      power_summary_i,
    input wire logic                      cal_quality_summary_i,
    input wire logic                      self_test_fail_i,
    input wire logic [W-1:0]              rdata_o,
    input wire logic                      rvalid_o,
    input wire logic                      op_summary_o,
    input wire logic                      ques_summary_o
);
    import status_pkg::*;
    logic [7:0] cond_rd;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            cond_rd[i] = req_i.rd && req_i.set_idx == 3'(i)
                         && req_i.sel == SEL_CONDITION;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    rd_answer_a: assert property (req_i.rd |=> rvalid_o)
        else $error("read not answered");
    bit15_zero_a: assert property (rvalid_o |-> !rdata_o[15])
        else $error("bit 15 read as one");
    meas_live_a: assert property (cond_rd[3] |=> rdata_o ==
        {13'h0, $past(chan_b_i.measuring), $past(chan_a_i.measuring), 1'b0})
        else $error("measuring bits wrong");
    sense_live_a: assert property (cond_rd[4] |=> rdata_o == {13'h0,
        $past(chan_b_i.sensor_mem_read), $past(chan_a_i.sensor_mem_read), 1'b0})
        else $error("sensor memory bits wrong");
    ques_map_a: assert property (cond_rd[7] |=> rdata_o ==
        {6'h0, $past(self_test_fail_i), $past(cal_quality_summary_i), 4'h0,
         $past(power_summary_i), 3'h0})
        else $error("questionable map wrong");
    op_unused_a: assert property (cond_rd[0] |=>
        (rdata_o & 16'hE3CE) == 16'h0000)
        else $error("unused operation bit set");
    cal_start_a: assert property (chan_a_i.cal_start ##1 cond_rd[1]
        |=> rdata_o[CH_A_BIT])
        else $error("calibrating bit not set");
    op_preset_a: assert property (preset_i |-> ##2 !op_summary_o)
        else $error("operation summary after preset");
    ques_preset_a: assert property (preset_i |-> ##2 !ques_summary_o)
        else $error("questionable summary after preset");
    cover property (op_summary_o);
    cover property (ques_summary_o);
    cover property (preset_i);
endmodule // status_regs_chk

bind operation_questionable_status_regs status_regs_chk #(.W(W)) u_chk (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
    .preset_i(preset_i), .chan_a_i(chan_a_i), .chan_b_i(chan_b_i),
    .limit_i(limit_i), .power_summary_i(power_summary_i),
    .cal_quality_summary_i(cal_quality_summary_i),
    .self_test_fail_i(self_test_fail_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .op_summary_o(op_summary_o),
    .ques_summary_o(ques_summary_o));

// ---- dv/status_host.sv ----
// Remote controller model issuing register set accesses
`timescale 1ns/100ps
module status_host (
    input  wire logic             sys_clk_i,
    input  wire logic [15:0]      rdata_i,
    input  wire logic             rvalid_i,
    output status_pkg::host_req_t req_o
);
    import status_pkg::*;
    initial req_o = '0;
    // Set index plus generic register selector
    task automatic acc(input logic w, input logic [2:0] s,
                       input reg_sel_t k, input logic [15:0] d,
                       output logic [15:0] q);
        @(posedge sys_clk_i);
        #1;
        req_o = '{rd: !w, wr: w, set_idx: s, sel: k, wdata: d};
        @(posedge sys_clk_i);
        #1;
        req_o.rd = 1'b0;
        req_o.wr = 1'b0;
        // Released data is scrambled so stale values never match
        req_o.wdata = ~req_o.wdata;
        q = (!w && rvalid_i !== 1'b1) ? 16'hXXXX : rdata_i;
    endtask
endmodule // status_host

// ---- dv/tb_top.sv ----
// Self-checking bench for the status register bank
`timescale 1ns/100ps
module tb_top;
    import status_pkg::*;
    logic          sys_clk = 1'b0;
    logic          rst_n   = 1'b0;
    host_req_t     req;
    logic          preset  = 1'b0;
    chan_status_t  cha     = '0;
    chan_status_t  chb     = '0;
    limit_result_t lim     = '0;
    logic          pw      = 1'b0;
    logic          cq      = 1'b0;
    logic          st      = 1'b0;
    logic [15:0]   rdata;
    logic          rvalid;
    logic          ops;
    logic          qs;
    logic [15:0]   q;
    int            err_count = 0;
    int            tests_run = 0;
    int            cyc = 0;

    operation_questionable_status_regs #(.W(16))
        u_operation_questionable_status_regs (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .req_i(req),
        .preset_i(preset), .chan_a_i(cha), .chan_b_i(chb), .limit_i(lim),
        .power_summary_i(pw), .cal_quality_summary_i(cq),
        .self_test_fail_i(st), .rdata_o(rdata), .rvalid_o(rvalid),
        .op_summary_o(ops), .ques_summary_o(qs));
    status_host u_status_host (.sys_clk_i(sys_clk), .rdata_i(rdata),
        .rvalid_i(rvalid), .req_o(req));

    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            conclude();
        end
    end

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0, got}, {15'h0, exp});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic rd(input logic [2:0] s, input reg_sel_t k);
        u_status_host.acc(1'b0, s, k, 16'h0000, q);
    endtask
    task automatic wr(input logic [2:0] s, input reg_sel_t k,
                      input logic [15:0] d);
        u_status_host.acc(1'b1, s, k, d, q);
    endtask
    task automatic chk_preset();
        for (int s = 0; s < 8; s++) begin
            rd(3'(s), SEL_ENABLE);
            chk16(q, (s == 0 || s == 7) ? ALL_ZEROS : ALL_ONES);
            rd(3'(s), SEL_POS_FILTER);
            chk16(q, ALL_ONES);
            rd(3'(s), SEL_NEG_FILTER);
            chk16(q, ALL_ZEROS);
        end
    endtask
    task automatic t_preset();
        cha.cal_start = 1'b1;
        cha.cal_start <= #40 1'b0;
        rd(SET_CALIBRATING, SEL_CONDITION);
        chk16(q, 16'h0002);
        for (int s = 0; s < 8; s++) begin
            wr(3'(s), SEL_ENABLE, 16'hF235);
            wr(3'(s), SEL_POS_FILTER, 16'h0F0F);
            wr(3'(s), SEL_NEG_FILTER, 16'h00FF);
        end
        rd(SET_MEASURING, SEL_ENABLE);
        chk16(q, 16'h7235);
        chk1(ops, 1'b1);
        preset = 1'b1;
        tick(1);
        preset = 1'b0;
        chk_preset();
        chk1(ops, 1'b0);
        rd(SET_CALIBRATING, SEL_CONDITION);
        chk16(q, 16'h0002);
        rd(SET_CALIBRATING, SEL_EVENT);
        chk16(q, 16'h0002);
        cha.cal_done = 1'b1;
        tick(1);
        cha.cal_done = 1'b0;
        tick(3);
        rd(SET_CALIBRATING, SEL_CONDITION);
        chk16(q, 16'h0000);
        rd(SET_CALIBRATING, SEL_EVENT);
        chk16(q, 16'h0000);
    endtask
    task automatic t_cal();
        for (int s = 0; s < 8; s++) rd(3'(s), SEL_EVENT);
        wr(SET_CALIBRATING, SEL_NEG_FILTER, 16'h0004);
        wr(SET_CALIBRATING, SEL_POS_FILTER, 16'h0002);
        wr(SET_OPERATION, SEL_ENABLE, 16'h0001);
        chb.cal_start = 1'b1;
        tick(1);
        chb.cal_start = 1'b0;
        tick(8);
        chk1(ops, 1'b0);
        rd(SET_CALIBRATING, SEL_CONDITION);
        chk16(q, 16'h0004);
        chb.cal_done = 1'b1;
        tick(1);
        chb.cal_done = 1'b0;
        tick(8);
        chk1(ops, 1'b1);
        rd(SET_OPERATION, SEL_CONDITION);
        chk16(q, 16'h0001);
        rd(SET_CALIBRATING, SEL_EVENT);
        chk16(q, 16'h0004);
        rd(SET_CALIBRATING, SEL_EVENT);
        chk16(q, 16'h0000);
        rd(SET_OPERATION, SEL_EVENT);
        chk16(q, 16'h0001);
        tick(3);
        chk1(ops, 1'b0);
    endtask
    task automatic t_limit();
        lim.lower_fail = 4'b1001;
        lim.upper_fail = 4'b0110;
        tick(1);
        lim = '0;
        tick(2);
        rd(SET_LOWER_FAIL, SEL_CONDITION);
        chk16(q, 16'h0012);
        rd(SET_UPPER_FAIL, SEL_CONDITION);
        chk16(q, 16'h000C);
        lim.measured = 4'hF;
        lim.lower_en = 4'h1;
        lim.upper_en = 4'hF;
        lim.upper_fail = 4'b0100;
        tick(1);
        lim = '0;
        tick(2);
        rd(SET_LOWER_FAIL, SEL_CONDITION);
        chk16(q, 16'h0010);
        rd(SET_UPPER_FAIL, SEL_CONDITION);
        chk16(q, 16'h0008);
    endtask
    task automatic t_levels();
        cha.measuring = 1'b1;
        chb.sensor_mem_read = 1'b1;
        rd(SET_MEASURING, SEL_CONDITION);
        chk16(q, 16'h0002);
        rd(SET_SENSOR_MEM, SEL_CONDITION);
        chk16(q, 16'h0004);
        cha.measuring = 1'b0;
        chb.sensor_mem_read = 1'b0;
        rd(SET_MEASURING, SEL_CONDITION);
        chk16(q, 16'h0000);
        chb.trig_enter_wait = 1'b1;
        tick(1);
        chb.trig_enter_wait = 1'b0;
        tick(2);
        rd(SET_TRIG_WAIT, SEL_CONDITION);
        chk16(q, 16'h0004);
        chb.trig_enter_idle = 1'b1;
        tick(1);
        chb.trig_enter_idle = 1'b0;
        tick(2);
        rd(SET_TRIG_WAIT, SEL_CONDITION);
        chk16(q, 16'h0000);
    endtask
    task automatic t_ques();
        st = 1'b1;
        pw = 1'b1;
        cq = 1'b1;
        rd(SET_QUESTIONABLE, SEL_CONDITION);
        chk16(q, 16'h0308);
        wr(SET_QUESTIONABLE, SEL_ENABLE, 16'h0200);
        tick(3);
        chk1(qs, 1'b1);
        rd(SET_QUESTIONABLE, SEL_EVENT);
        chk16(q, 16'h0308);
        tick(2);
        chk1(qs, 1'b0);
    endtask
    task automatic conclude();
        $display("Errors %0d, checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        tick(16);
        rst_n = 1'b1;
        chk_preset();
        t_preset();
        t_cal();
        t_limit();
        t_levels();
        t_ques();
        conclude();
    end
endmodule // tb_top
